// >>> disk_track_pkg.sv
// Shared constants, encodings and helper functions for the disk track and segment addressing block.
// Assumes a single 125 MHz clock domain and a 32-bit AHB-Lite register bus.
package disk_track_pkg;
  localparam int WORD_W = 13;
  localparam int SAMPLE_W = 12;
  localparam int TRACKS = 8;
  localparam int TRACK_W = 3;
  localparam int OFF_W = 10;
  localparam int QUARTERS = 4;
  localparam int MEM_AW = 12;
  localparam int CNT_W = 13;
  localparam int FIFO_DEPTH = 16;

  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] PROTECT_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;

  // Control register fields
  localparam int CTRL_STORE_BIT = 0;
  localparam int CTRL_RECALL_BIT = 1;
  localparam int CTRL_STEP_BIT = 2;
  localparam int CTRL_SEPARATE_BIT = 3;
  localparam int CTRL_MEMGRP_LSB = 4;
  localparam int CTRL_SEGSEL_LSB = 8;
  localparam int GRP_W = 3;

  // Status register fields
  localparam int STAT_TRACK_LSB = 0;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_ABORT_BIT = 4;
  localparam int STAT_WP_BIT = 5;
  localparam int STAT_DONE_BIT = 6;
  localparam int STAT_STORE_BIT = 7;

  localparam logic [10:0] CTRL_RESET = 11'h000;
  localparam logic [7:0] PROTECT_RESET = 8'h00;

  // Memory group and disk segment selector codes
  localparam logic [2:0] GRP_ALL = 3'h0;
  localparam logic [2:0] GRP_HALF_FIRST = 3'h1;
  localparam logic [2:0] GRP_HALF_SECOND = 3'h2;
  localparam logic [2:0] GRP_QUARTER_ONE = 3'h3;
  localparam logic [2:0] GRP_QUARTER_TWO = 3'h4;
  localparam logic [2:0] GRP_QUARTER_THREE = 3'h5;
  localparam logic [2:0] GRP_QUARTER_FOUR = 3'h6;

  // Quarter masks, bit n is quarter n+1; first half is quarters one and three
  localparam logic [3:0] MASK_ALL = 4'hF;
  localparam logic [3:0] MASK_HALF_FIRST = 4'h5;
  localparam logic [3:0] MASK_HALF_SECOND = 4'hA;

  function automatic logic [3:0] grp_mask(input logic [2:0] grp);
    logic [3:0] m;
    case (grp)
      GRP_HALF_FIRST: m = MASK_HALF_FIRST;
      GRP_HALF_SECOND: m = MASK_HALF_SECOND;
      GRP_QUARTER_ONE: m = 4'h1;
      GRP_QUARTER_TWO: m = 4'h2;
      GRP_QUARTER_THREE: m = 4'h4;
      GRP_QUARTER_FOUR: m = 4'h8;
      default: m = MASK_ALL;
    endcase
    return m;
  endfunction : grp_mask

  function automatic logic [2:0] pop4(input logic [3:0] m);
    return 3'({2'h0, m[0]} + {2'h0, m[1]} + {2'h0, m[2]} + {2'h0, m[3]});
  endfunction : pop4

  // Quarter index of the n-th set bit, wrapping if the mask is smaller
  function automatic logic [1:0] nth_q(input logic [3:0] mask, input logic [1:0] n);
    logic [1:0] r;
    logic [2:0] tgt;
    logic [2:0] seen;
    logic found;
    r = 2'h0;
    seen = 3'h0;
    found = 1'b0;
    tgt = (pop4(mask) == 3'h0) ? 3'h0 : 3'({1'b0, n} % pop4(mask));
    for (int p = 0; p < QUARTERS; p++) begin
      if (mask[p]) begin
        if (!found && seen == tgt) begin
          r = 2'(p);
          found = 1'b1;
        end
        seen = 3'(seen + 3'h1);
      end
    end
    return r;
  endfunction : nth_q
endpackage : disk_track_pkg

// >>> word_stream_if.sv
// Valid/ready word stream between the transfer sequencer and the buffer.
// Assumes both ends share one clock.
interface word_stream_if #(parameter int WIDTH = 13);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : word_stream_if

// >>> word_fifo.sv
// Word FIFO with a registered output stage.
// Assumes one clock; the drain side may stall freely.
module word_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  word_stream_if.snk fill,
  word_stream_if.src drain
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic out_valid_ff;
  logic [WIDTH-1:0] out_data_ff;
  logic push;
  logic load;

  assign fill.ready = (count_ff != (AW+1)'(DEPTH));
  assign push = fill.valid && fill.ready;
  assign load = (count_ff != '0) && (!out_valid_ff || drain.ready);
  assign drain.valid = out_valid_ff;
  assign drain.data = out_data_ff;

  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= fill.data;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= AW'(wr_ptr_ff + 1'b1);
      end
      if (load) begin
        rd_ptr_ff <= AW'(rd_ptr_ff + 1'b1);
      end
      count_ff <= (AW+1)'(count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, load});
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      out_valid_ff <= 1'b0;
      out_data_ff <= '0;
    end else if (load) begin
      out_valid_ff <= 1'b1;
      out_data_ff <= mem_ff[rd_ptr_ff];
    end else if (drain.ready) begin
      out_valid_ff <= 1'b0;
    end
  end
endmodule : word_fifo

// >>> disk_track_segment_addressing.sv
// Track pointer, protection and segment addressing of the waveform disk store, with AHB-Lite registers.
// Assumes main memory reads combinationally in the request cycle and the drive acks each word.
//
// Function
// - Eight tracks, four 1024-word segments each
// - Disk words are 13 bits wide
// - Quarters one, three form first half
// - Advance track after each operation, wrap
// - Store skips tracks with protect switch set
// - Write-protected medium blocks writes, lights lamp; checked only when a store starts, a store already running keeps writing
// - Eight lamps show next track used
// - Whole-memory store writes whole track in order
// - Normal mode: memory group picks disk segments
// - Unselected disk segments stay unchanged
// - Partial recall leaves other memory unchanged
// - Separate mode: segment selector picks disk segments
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
module disk_track_segment_addressing (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  input wire logic disk_wp_in,
  input wire logic track_step_in,
  output logic [11:0] mem_addr_out,
  output logic mem_rd_out,
  input wire logic [12:0] mem_rdata_in,
  output logic mem_wr_out,
  output logic [12:0] mem_wdata_out,
  output logic [2:0] disk_track_out,
  output logic [11:0] disk_addr_out,
  output logic disk_rd_out,
  input wire logic disk_rd_ack_in,
  input wire logic [12:0] disk_rdata_in,
  output logic disk_wr_out,
  input wire logic disk_wr_ack_in,
  output logic [12:0] disk_wdata_out,
  output logic [7:0] track_lamp_out,
  output logic disk_protected_led_out
);
  typedef enum logic {ST_IDLE, ST_XFER} state_t;

  state_t state_ff;
  logic [10:0] ctrl_ff;
  logic [7:0] protect_ff;
  logic [disk_track_pkg::TRACK_W-1:0] track_ff;
  logic abort_ff;
  logic done_ff;
  logic op_store_ff;
  logic [3:0] disk_mask_ff;
  logic [3:0] mem_mask_ff;
  logic [disk_track_pkg::CNT_W-1:0] total_ff;
  logic [disk_track_pkg::CNT_W-1:0] src_cnt_ff;
  logic [disk_track_pkg::CNT_W-1:0] snk_cnt_ff;

  // AHB-Lite slave state
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic take;

  // Pin synchronisers
  logic [2:0] wp_sync_ff;
  logic [2:0] step_sync_ff;
  logic wp_ff;
  logic step_ff;
  logic step_prev_ff;

  word_stream_if #(.WIDTH(disk_track_pkg::WORD_W)) fill_if ();
  word_stream_if #(.WIDTH(disk_track_pkg::WORD_W)) drain_if ();

  word_fifo #(
    .WIDTH(disk_track_pkg::WORD_W),
    .DEPTH(disk_track_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .fill(fill_if.snk),
    .drain(drain_if.src)
  );

  // Register bus
  assign take = hsel_in && htrans_in[1] && hready_in;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign hrdata_out = hrdata_ff;

  logic wr_ctrl;
  logic wr_protect;
  logic wr_status;
  assign wr_ctrl = wr_pend_ff && (wr_addr_ff == disk_track_pkg::CTRL_ADDR);
  assign wr_protect = wr_pend_ff && (wr_addr_ff == disk_track_pkg::PROTECT_ADDR);
  assign wr_status = wr_pend_ff && (wr_addr_ff == disk_track_pkg::STATUS_ADDR);

  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[disk_track_pkg::STAT_TRACK_LSB +: disk_track_pkg::TRACK_W] = track_ff;
    status_word[disk_track_pkg::STAT_BUSY_BIT] = (state_ff == ST_XFER);
    status_word[disk_track_pkg::STAT_ABORT_BIT] = abort_ff;
    status_word[disk_track_pkg::STAT_WP_BIT] = wp_ff;
    status_word[disk_track_pkg::STAT_DONE_BIT] = done_ff;
    status_word[disk_track_pkg::STAT_STORE_BIT] = op_store_ff;
  end

  logic [31:0] nxt_hrdata;
  always_comb begin
    case (haddr_in[7:0])
      disk_track_pkg::CTRL_ADDR: nxt_hrdata = {21'h000000, ctrl_ff};
      disk_track_pkg::PROTECT_ADDR: nxt_hrdata = {24'h000000, protect_ff};
      disk_track_pkg::STATUS_ADDR: nxt_hrdata = status_word;
      default: nxt_hrdata = 32'h0000_0000;
    endcase
    if (haddr_in[31:8] != 24'h000000) begin
      nxt_hrdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= take && hwrite_in && (haddr_in[31:8] == 24'h000000);
      if (take) begin
        wr_addr_ff <= haddr_in[7:0];
      end
      hrdata_ff <= (take && !hwrite_in) ? nxt_hrdata : 32'h0000_0000;
    end
  end

  // Strobe bits are not stored, so the control word reads back only mode and selectors
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_ff <= disk_track_pkg::CTRL_RESET;
      protect_ff <= disk_track_pkg::PROTECT_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= {hwdata_in[10:3], 3'h0};
      end
      if (wr_protect) begin
        protect_ff <= hwdata_in[7:0];
      end
    end
  end

  // Change counts once stages two and three agree
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wp_sync_ff <= 3'h0;
      step_sync_ff <= 3'h0;
      wp_ff <= 1'b0;
      step_ff <= 1'b0;
      step_prev_ff <= 1'b0;
    end else begin
      wp_sync_ff <= {wp_sync_ff[1:0], disk_wp_in};
      step_sync_ff <= {step_sync_ff[1:0], track_step_in};
      if (wp_sync_ff[1] == wp_sync_ff[2]) begin
        wp_ff <= wp_sync_ff[2];
      end
      if (step_sync_ff[1] == step_sync_ff[2]) begin
        step_ff <= step_sync_ff[2];
      end
      step_prev_ff <= step_ff;
    end
  end

  // Operation requests
  logic idle;
  logic req_store;
  logic req_recall;
  logic req_step;
  logic separate;
  logic [2:0] mem_grp;
  logic [2:0] seg_sel;
  assign idle = (state_ff == ST_IDLE);
  assign req_store = idle && wr_ctrl && hwdata_in[disk_track_pkg::CTRL_STORE_BIT];
  assign req_recall = idle && wr_ctrl && hwdata_in[disk_track_pkg::CTRL_RECALL_BIT] && !req_store;
  assign req_step = idle && ((wr_ctrl && hwdata_in[disk_track_pkg::CTRL_STEP_BIT]) || (step_ff && !step_prev_ff));
  assign separate = hwdata_in[disk_track_pkg::CTRL_SEPARATE_BIT];
  assign mem_grp = hwdata_in[disk_track_pkg::CTRL_MEMGRP_LSB +: disk_track_pkg::GRP_W];
  assign seg_sel = hwdata_in[disk_track_pkg::CTRL_SEGSEL_LSB +: disk_track_pkg::GRP_W];

  // First unprotected track at or after the pointer
  logic [disk_track_pkg::TRACK_W-1:0] free_track;
  logic free_found;
  always_comb begin
    logic [disk_track_pkg::TRACK_W-1:0] idx;
    idx = track_ff;
    free_track = track_ff;
    free_found = 1'b0;
    for (int i = 0; i < disk_track_pkg::TRACKS; i++) begin
      idx = disk_track_pkg::TRACK_W'(track_ff + 3'(i));
      if (!free_found && !protect_ff[idx]) begin
        free_track = idx;
        free_found = 1'b1;
      end
    end
  end

  logic store_ok;
  logic store_abort;
  assign store_ok = req_store && !wp_ff && free_found;
  assign store_abort = req_store && (wp_ff || !free_found);

  // Transfer addressing: k-th disk segment pairs with k-th memory quarter
  logic xfer;
  logic src_busy;
  logic [1:0] src_k;
  logic [1:0] snk_k;
  logic [disk_track_pkg::OFF_W-1:0] src_off;
  logic [disk_track_pkg::OFF_W-1:0] snk_off;
  logic [11:0] src_mem_addr;
  logic [11:0] snk_mem_addr;
  logic [11:0] src_disk_addr;
  logic [11:0] snk_disk_addr;
  logic sink_take;
  logic op_done;
  assign xfer = (state_ff == ST_XFER);
  assign src_busy = xfer && (src_cnt_ff != total_ff);
  assign src_k = src_cnt_ff[11:10];
  assign snk_k = snk_cnt_ff[11:10];
  assign src_off = src_cnt_ff[disk_track_pkg::OFF_W-1:0];
  assign snk_off = snk_cnt_ff[disk_track_pkg::OFF_W-1:0];
  assign src_mem_addr = {disk_track_pkg::nth_q(mem_mask_ff, src_k), src_off};
  assign snk_mem_addr = {disk_track_pkg::nth_q(mem_mask_ff, snk_k), snk_off};
  assign src_disk_addr = {disk_track_pkg::nth_q(disk_mask_ff, src_k), src_off};
  assign snk_disk_addr = {disk_track_pkg::nth_q(disk_mask_ff, snk_k), snk_off};
  assign sink_take = drain_if.valid && drain_if.ready;
  assign op_done = xfer && (snk_cnt_ff == total_ff);

  // Source side feeds the FIFO, stalled by its ready
  assign mem_rd_out = src_busy && op_store_ff && fill_if.ready;
  assign disk_rd_out = src_busy && !op_store_ff && fill_if.ready;
  assign fill_if.valid = op_store_ff ? mem_rd_out : (disk_rd_out && disk_rd_ack_in);
  assign fill_if.data = op_store_ff ? mem_rdata_in : disk_rdata_in;

  // Sink side drains the FIFO; the drive may stall stores
  assign disk_wr_out = xfer && op_store_ff && drain_if.valid;
  assign mem_wr_out = xfer && !op_store_ff && drain_if.valid;
  assign drain_if.ready = xfer && (op_store_ff ? disk_wr_ack_in : 1'b1);
  assign disk_wdata_out = drain_if.data;
  assign mem_wdata_out = drain_if.data;

  assign mem_addr_out = op_store_ff ? src_mem_addr : snk_mem_addr;
  assign disk_addr_out = op_store_ff ? snk_disk_addr : src_disk_addr;
  assign disk_track_out = track_ff;
  assign disk_protected_led_out = wp_ff;

  for (genvar t = 0; t < disk_track_pkg::TRACKS; t++) begin : g_lamp
    assign track_lamp_out[t] = (track_ff == disk_track_pkg::TRACK_W'(t));
  end

  // Sequencer
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (store_ok || req_recall) begin
            state_ff <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (op_done) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Masks latched at start; normal mode uses the memory group for both sides
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      op_store_ff <= 1'b0;
      disk_mask_ff <= disk_track_pkg::MASK_ALL;
      mem_mask_ff <= disk_track_pkg::MASK_ALL;
      total_ff <= '0;
    end else if (store_ok || req_recall) begin
      op_store_ff <= store_ok;
      mem_mask_ff <= disk_track_pkg::grp_mask(mem_grp);
      if (separate) begin
        disk_mask_ff <= disk_track_pkg::grp_mask(seg_sel);
        total_ff <= {disk_track_pkg::pop4(disk_track_pkg::grp_mask(seg_sel)), 10'h000};
      end else begin
        disk_mask_ff <= disk_track_pkg::grp_mask(mem_grp);
        total_ff <= {disk_track_pkg::pop4(disk_track_pkg::grp_mask(mem_grp)), 10'h000};
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      src_cnt_ff <= '0;
      snk_cnt_ff <= '0;
    end else if (store_ok || req_recall) begin
      src_cnt_ff <= '0;
      snk_cnt_ff <= '0;
    end else begin
      if (fill_if.valid && fill_if.ready) begin
        src_cnt_ff <= disk_track_pkg::CNT_W'(src_cnt_ff + 1'b1);
      end
      if (sink_take) begin
        snk_cnt_ff <= disk_track_pkg::CNT_W'(snk_cnt_ff + 1'b1);
      end
    end
  end

  // Track pointer
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      track_ff <= '0;
    end else if (store_ok) begin
      track_ff <= free_track;
    end else if (op_done) begin
      track_ff <= disk_track_pkg::TRACK_W'(track_ff + 1'b1);
    end else if (req_step && !req_store && !req_recall) begin
      track_ff <= disk_track_pkg::TRACK_W'(track_ff + 1'b1);
    end
  end

  // Sticky flags; a set in the clearing cycle wins
  logic clr_abort;
  logic clr_done;
  assign clr_abort = wr_status && hwdata_in[disk_track_pkg::STAT_ABORT_BIT];
  assign clr_done = wr_status && hwdata_in[disk_track_pkg::STAT_DONE_BIT];

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      abort_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      abort_ff <= store_abort || (abort_ff && !clr_abort);
      done_ff <= op_done || (done_ff && !clr_done);
    end
  end
endmodule : disk_track_segment_addressing

// >>> disk_track_segment_addressing_chk.sv
// Port-level checks for the disk track and segment addressing block.
// Assumes one clock domain; attached to every instance of the top module by bind.
module disk_track_segment_addressing_chk (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic disk_wp_in,
  input wire logic [11:0] mem_addr_out,
  input wire logic mem_rd_out,
  input wire logic mem_wr_out,
  input wire logic [2:0] disk_track_out,
  input wire logic [11:0] disk_addr_out,
  input wire logic disk_rd_out,
  input wire logic disk_rd_ack_in,
  input wire logic disk_wr_out,
  input wire logic disk_wr_ack_in,
  input wire logic [12:0] disk_wdata_out,
  input wire logic [7:0] track_lamp_out,
  input wire logic disk_protected_led_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  property p_lamp; track_lamp_out == (8'h01 << disk_track_out); endproperty
  a_lamp: assert property (p_lamp) else $error("lamp does not match track");
  property p_wr_hold;
    disk_wr_out && !disk_wr_ack_in |=> disk_wr_out && $stable(disk_addr_out) && $stable(disk_wdata_out);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("disk write dropped before ack");
  property p_rd_hold;
    disk_rd_out && !disk_rd_ack_in |=> disk_rd_out && $stable(disk_addr_out) && $stable(disk_track_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("disk read dropped before ack");
  property p_wp_block; disk_protected_led_out |-> !disk_wr_out; endproperty
  a_wp_block: assert property (p_wp_block) else $error("write to protected disk");
  property p_led; $rose(disk_wp_in) |-> ##[1:6] disk_protected_led_out; endproperty
  a_led: assert property (p_led) else $error("protect lamp not lit");
  property p_excl; mem_wr_out |-> !disk_wr_out && !mem_rd_out; endproperty
  a_excl: assert property (p_excl) else $error("recall overlaps store traffic");
  property p_trk; disk_wr_out && $past(disk_wr_out) |-> $stable(disk_track_out); endproperty
  a_trk: assert property (p_trk) else $error("track moved during store");
  property p_dseq;
    disk_wr_out && disk_wr_ack_in && disk_addr_out[9:0] != 10'h3FF
      |=> !disk_wr_out || disk_addr_out[9:0] == $past(disk_addr_out[9:0]) + 10'h1;
  endproperty
  a_dseq: assert property (p_dseq) else $error("disk offset not ascending");
  property p_mseq;
    mem_rd_out && mem_addr_out[9:0] != 10'h3FF |=> !mem_rd_out || mem_addr_out[9:0] == $past(mem_addr_out[9:0]) + 10'h1;
  endproperty
  a_mseq: assert property (p_mseq) else $error("memory offset not ascending");
  c_store: cover property (disk_wr_out && disk_wr_ack_in);
  c_recall: cover property (mem_wr_out);
  c_led: cover property ($rose(disk_protected_led_out));
endmodule : disk_track_segment_addressing_chk

bind disk_track_segment_addressing disk_track_segment_addressing_chk u_chk (
  .core_clk_in, .reset_n_in, .disk_wp_in, .mem_addr_out, .mem_rd_out, .mem_wr_out, .disk_track_out,
  .disk_addr_out, .disk_rd_out, .disk_rd_ack_in, .disk_wr_out, .disk_wr_ack_in, .disk_wdata_out,
  .track_lamp_out, .disk_protected_led_out
);

// >>> disk_mem_model.sv
// Disk drive and main memory standing at the far side of the addressing block.
// Assumes one clock; acks are registered, and slow mode acks only every fourth cycle.
module disk_mem_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic slow_in,
  input wire logic [11:0] mem_addr_in,
  input wire logic mem_rd_in,
  output logic [12:0] mem_rdata_out,
  input wire logic mem_wr_in,
  input wire logic [12:0] mem_wdata_in,
  input wire logic [2:0] track_in,
  input wire logic [11:0] disk_addr_in,
  input wire logic disk_rd_in,
  output logic rd_ack_out,
  output logic [12:0] disk_rdata_out,
  input wire logic disk_wr_in,
  output logic wr_ack_out,
  input wire logic [12:0] disk_wdata_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] mem [4096];
  logic [12:0] disk [8][4096];
  logic [1:0] cnt_ff;
  wire logic [12:0] dword = disk[track_in][disk_addr_in];
  // Idle data lines show the inverse so a stale value never matches
  assign mem_rdata_out = mem_rd_in ? mem[mem_addr_in] : ~mem[mem_addr_in];
  assign disk_rdata_out = rd_ack_out ? dword : ~dword;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff <= 2'h0;
      rd_ack_out <= 1'b0;
      wr_ack_out <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
      rd_ack_out <= disk_rd_in && !rd_ack_out && (!slow_in || cnt_ff == 2'h3);
      wr_ack_out <= disk_wr_in && !wr_ack_out && (!slow_in || cnt_ff == 2'h3);
    end
  end
  always @(posedge clk_in) begin
    if (disk_wr_in && wr_ack_out) disk[track_in][disk_addr_in] <= disk_wdata_in;
    if (mem_wr_in) mem[mem_addr_in] <= mem_wdata_in;
  end
endmodule : disk_mem_model

// >>> tb_disk_track_segment_addressing.sv
// Self-checking bench: table of store and recall cases, then protection, step and abort cases.
// Assumes the far-side model and a shadow copy of disk and memory kept by the bench.
module tb_disk_track_segment_addressing;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic st; logic sep; logic [2:0] grp; logic [2:0] seg; logic slow; logic [2:0] trk;} row_t;
  row_t rows [8] = '{'{1'h1, 1'h0, 3'h0, 3'h0, 1'h0, 3'h1}, '{1'h0, 1'h0, 3'h1, 3'h0, 1'h0, 3'h2},
    '{1'h1, 1'h1, 3'h6, 3'h3, 1'h0, 3'h3}, '{1'h0, 1'h1, 3'h2, 3'h1, 1'h0, 3'h4},
    '{1'h1, 1'h0, 3'h4, 3'h0, 1'h1, 3'h5}, '{1'h0, 1'h0, 3'h5, 3'h0, 1'h0, 3'h6},
    '{1'h1, 1'h0, 3'h7, 3'h0, 1'h0, 3'h7}, '{1'h0, 1'h1, 3'h3, 3'h6, 1'h0, 3'h0}};
  logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, wp = 1'b0, step = 1'b0, slow = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic hready, hresp, mem_rd, mem_wr, rd_ack, wr_ack, disk_rd, disk_wr, led;
  logic [11:0] mem_addr, disk_addr;
  logic [12:0] mem_rdata, mem_wdata, disk_rdata, disk_wdata, sdisk [8][4096], smem [4096];
  logic [2:0] trk, cur = 3'h0;
  logic [7:0] lamp;
  int errors = 0, total_checks = 0, cyc = 0;
  disk_track_segment_addressing u_dut (.core_clk_in(clk), .reset_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata), .disk_wp_in(wp), .track_step_in(step),
    .mem_addr_out(mem_addr), .mem_rd_out(mem_rd), .mem_rdata_in(mem_rdata), .mem_wr_out(mem_wr),
    .mem_wdata_out(mem_wdata), .disk_track_out(trk), .disk_addr_out(disk_addr), .disk_rd_out(disk_rd),
    .disk_rd_ack_in(rd_ack), .disk_rdata_in(disk_rdata), .disk_wr_out(disk_wr), .disk_wr_ack_in(wr_ack),
    .disk_wdata_out(disk_wdata), .track_lamp_out(lamp), .disk_protected_led_out(led));
  disk_mem_model u_model (.clk_in(clk), .rst_n_in(rst_n), .slow_in(slow), .mem_addr_in(mem_addr),
    .mem_rd_in(mem_rd), .mem_rdata_out(mem_rdata), .mem_wr_in(mem_wr), .mem_wdata_in(mem_wdata),
    .track_in(trk), .disk_addr_in(disk_addr), .disk_rd_in(disk_rd), .rd_ack_out(rd_ack),
    .disk_rdata_out(disk_rdata), .disk_wr_in(disk_wr), .wr_ack_out(wr_ack), .disk_wdata_in(disk_wdata));
  always #4 clk = ~clk;
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  // Whole ops take under 50k cycles; twice that means a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      errors++;
      stop_test();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    if (!w) q = hrdata;
  endtask : ahb
  function automatic logic [3:0] msk(input logic [2:0] g);
    case (g)
      3'h1: return 4'h5;
      3'h2: return 4'hA;
      3'h3: return 4'h1;
      3'h4: return 4'h2;
      3'h5: return 4'h4;
      3'h6: return 4'h8;
      default: return 4'hF;
    endcase
  endfunction : msk
  task xfer(input logic st, input logic [3:0] dm, input logic [3:0] mm, input logic [2:0] t);
    int k;
    int n;
    k = 0;
    for (int dq = 0; dq < 4; dq++) begin
      if (dm[dq]) begin
        n = 0;
        for (int mq = 0; mq < 4; mq++) begin
          if (mm[mq]) begin
            for (int o = 0; o < 1024 && n == k; o++) begin
              if (st) sdisk[t][dq * 1024 + o] = smem[mq * 1024 + o];
              else smem[mq * 1024 + o] = sdisk[t][dq * 1024 + o];
            end
            n++;
          end
        end
        k++;
      end
    end
  endtask : xfer
  task run(input logic st, input logic sep, input logic [2:0] g, input logic [2:0] sg, input logic [2:0] t,
      input logic ab);
    int d;
    ahb(1'b1, 32'h0, {21'h0, sg, 1'b0, g, sep, 1'b0, !st, st});
    q = 32'h0;
    for (int i = 0; i < 5000 && !(q[6] || q[4]); i++) ahb(1'b0, 32'h8, 32'h0);
    chk("abort", {31'h0, ab}, {31'h0, q[4]});
    ahb(1'b1, 32'h8, 32'h50);
    if (!ab) xfer(st, sep ? msk(sg) : msk(g), msk(g), t);
    d = 0;
    for (int a = 0; a < 4096; a++) begin
      if (u_model.mem[a] !== smem[a]) d++;
      for (int k = 0; k < 8; k++) if (u_model.disk[k][a] !== sdisk[k][a]) d++;
    end
    chk("words_differing", 32'h0, 32'(d));
  endtask : run
  initial begin
    for (int a = 0; a < 4096; a++) begin
      smem[a] = 13'(a) ^ 13'h1555;
      u_model.mem[a] = smem[a];
      for (int t = 0; t < 8; t++) begin
        sdisk[t][a] = 13'(a + t * 512);
        u_model.disk[t][a] = sdisk[t][a];
      end
    end
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    chk("lamp", 32'h1, {24'h0, lamp});
    ahb(1'b0, 32'h4, 32'h0);
    chk("protect", 32'h0, q);
    ahb(1'b0, 32'hC, 32'h0);
    chk("unmapped", 32'h0, q);
    for (int i = 0; i < 8; i++) begin
      slow <= rows[i].slow;
      run(rows[i].st, rows[i].sep, rows[i].grp, rows[i].seg, cur, 1'b0);
      cur = rows[i].trk;
      chk("status", {28'h0, rows[i].st, cur}, {28'h0, q[7], q[2:0]});
      chk("track", {29'h0, cur}, {29'h0, trk});
      $display("row %0d done", i);
    end
    ahb(1'b1, 32'h4, 32'h3);
    run(1'b1, 1'b0, 3'h3, 3'h0, 3'h2, 1'b0);
    chk("track", 32'h3, {29'h0, trk});
    chk("led", 32'h0, {30'h0, hresp, led});
    $display("protect skip done");
    ahb(1'b1, 32'h4, 32'hFF);
    run(1'b1, 1'b0, 3'h3, 3'h0, 3'h0, 1'b1);
    chk("track", 32'h3, {29'h0, trk});
    ahb(1'b1, 32'h4, 32'h0);
    step <= 1'b1;
    repeat (6) @(posedge clk);
    step <= 1'b0;
    repeat (12) @(posedge clk);
    chk("track", 32'h4, {29'h0, trk});
    ahb(1'b1, 32'h0, 32'h4);
    wp <= 1'b1;
    repeat (8) @(posedge clk);
    chk("led", 32'h1, {30'h0, hresp, led});
    run(1'b1, 1'b0, 3'h0, 3'h0, 3'h0, 1'b1);
    chk("track", 32'h5, {29'h0, trk});
    wp <= 1'b0;
    $display("protect abort and step done");
    stop_test();
  end
endmodule : tb_disk_track_segment_addressing
